// ===== design/mdfp_defs.svh
// Constants for the fault protection block.
// Assumes inclusion by bare name from design files only.
`ifndef MDFP_DEFS_SVH
`define MDFP_DEFS_SVH

// Clock period and buck overcurrent deglitch time, in ns
`define MDFP_CLK_PERIOD_NS 4
`define MDFP_OCP_DEG_NS 1000
`define MDFP_OCP_DEG_CYC ((`MDFP_OCP_DEG_NS + `MDFP_CLK_PERIOD_NS - 1) / `MDFP_CLK_PERIOD_NS)

// Stall filter step in ns and lock retry step in clock cycles, per unit of the select code
`define MDFP_STALL_STEP_NS 1000
`define MDFP_STALL_STEP_CYC (`MDFP_STALL_STEP_NS / `MDFP_CLK_PERIOD_NS)
`define MDFP_RETRY_STEP_CYC 250000

// Reset values of control state
`define MDFP_PULSE_SEL_RST 4'h0
`define MDFP_STALL_SEL_RST 4'h0

// Pulse report-only code; other codes decode by field bits
`define MDFP_PL_REPORT 4'h6

// Stall response field positions
`define MDFP_ST_MODE_HI 3
`define MDFP_ST_MODE_LO 2
`define MDFP_ST_BRIDGE_HI 1
`define MDFP_ST_BRIDGE_LO 0
`define MDFP_ST_REPORT 4'h8

`endif

// ===== design/mdfp_pkg.sv
// Types shared by the fault protection block.
// Assumes nothing beyond a SystemVerilog compiler.
package mdfp_pkg;
    typedef enum logic [1:0] {
        MDFP_BR_OFF,
        MDFP_BR_RECIRC,
        MDFP_BR_HS_BRAKE,
        MDFP_BR_LS_BRAKE
    } mdfp_bridge_t;
endpackage

// ===== design/mdfp_sync_if.sv
// Interface carrying synchronised threshold flags to the fault logic.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface mdfp_sync_if;
    logic buck_oc;
    logic pulse_over_cl;
    logic pulse_over_ol;
    logic stall_over;
    logic temp_warn;
    logic temp_warn_hys;
    logic temp_sd;
    logic temp_sd_hys;
    logic pwm_start;
    modport src (output buck_oc, pulse_over_cl, pulse_over_ol, stall_over, temp_warn,
        temp_warn_hys, temp_sd, temp_sd_hys, pwm_start);
    modport dst (input buck_oc, pulse_over_cl, pulse_over_ol, stall_over, temp_warn,
        temp_warn_hys, temp_sd, temp_sd_hys, pwm_start);
endinterface

// ===== design/mdfp_sync.sv
// Two-flop synchronisers for the analog threshold flags.
// Assumes raw levels from outside the core clock domain.
`timescale 1ns/1ns
module mdfp_sync (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [8:0] i_raw,
    mdfp_sync_if.src o_flags
);
    logic [8:0] meta_q;
    logic [8:0] sync_q;

    // ------------------------------------------------------------
    // Synchroniser chain per flag
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : g_bit
            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= i_raw[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_flags.buck_oc = sync_q[0];
    assign o_flags.pulse_over_cl = sync_q[1];
    assign o_flags.pulse_over_ol = sync_q[2];
    assign o_flags.stall_over = sync_q[3];
    assign o_flags.temp_warn = sync_q[4];
    assign o_flags.temp_warn_hys = sync_q[5];
    assign o_flags.temp_sd = sync_q[6];
    assign o_flags.temp_sd_hys = sync_q[7];
    assign o_flags.pwm_start = sync_q[8];
endmodule

// ===== design/mdfp_top.sv
// Fault response logic: buck overcurrent, pulse limit, stall limit, thermal.
// Assumes outside comparators drive the raw flags and a
// controller reads status and clears faults over APB.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "mdfp_defs.svh"

// Summary of operation
// - Buck switch overcurrent lasting past the deglitch time holds the reset request high until the overcurrent ends.
// - Sense over pulse threshold is a limit event handled per the 4-bit response.
// - Closed loop uses closed-loop threshold flag, open loop the open-loop one.
// - Codes 000x recirculate and flag until the next PWM cycle start.
// - 0000 also reports error and pin low; 0001 reports neither.
// - Codes 001x recirculate until sense drops; 0010 also reports error and pin.
// - Codes 010x recirculate hold count plus one PWM cycles; 0100 also reports.
// - Code 0110 only flags; flags clear after condition gone and clear command.
// - Code 0111 and 1xxx ignore limit events entirely.
// - Stall event needs sampled sense above stall threshold past filter time.
// - Stall latched or retry picks bridge state from low bits and pulls pin low.
// - Stall latched sets flags; resumes after condition gone and clear command.
// - Stall retry sets flags; after retry delay resume and clear both flags.
// - Stall code 1000 only flags; clear after condition gone and clear command.
// - Stall codes 1xx1 ignore stall events.
// - Warning temperature sets flags; pin only when warning-to-pin enable set.
// - Warning pin releases below hysteresis; flag clears on command below limit.
// - Shutdown temperature asserts bridge override, stops pump, pin low, sets flags.
// - Shutdown ends below hysteresis; shutdown flag latched until clear command.
module mdfp_top
    import mdfp_pkg::*;
#(
    parameter int RETRY_STEP_CYC = `MDFP_RETRY_STEP_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_buck_oc_raw,
    input wire logic i_pulse_over_cl_raw,
    input wire logic i_pulse_over_ol_raw,
    input wire logic i_stall_over_raw,
    input wire logic i_temp_warn_raw,
    input wire logic i_temp_warn_hys_raw,
    input wire logic i_temp_sd_raw,
    input wire logic i_temp_sd_hys_raw,
    input wire logic i_pwm_start_raw,
    input wire logic i_closed_loop,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_fault_pin_n,
    output logic o_bridge_override,
    output mdfp_bridge_t o_bridge_state,
    output logic o_charge_pump_en,
    output logic o_buck_reset_req
);
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_CMD = 12'h008;

    mdfp_sync_if flags ();

    mdfp_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_raw({i_pwm_start_raw, i_temp_sd_hys_raw, i_temp_sd_raw, i_temp_warn_hys_raw,
            i_temp_warn_raw, i_stall_over_raw, i_pulse_over_ol_raw, i_pulse_over_cl_raw,
            i_buck_oc_raw}),
        .o_flags(flags)
    );

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [3:0] pulse_sel_q;
    logic [3:0] stall_sel_q;
    logic [3:0] hold_cyc_q;
    logic [3:0] stall_filt_q;
    logic [3:0] retry_sel_q;
    logic warn_pin_en_q;
    logic ctl_err_q;
    logic gate_err_q;
    logic pulse_flag_q;
    logic stall_flag_q;
    logic ot_flag_q;
    logic warn_flag_q;
    logic sd_flag_q;
    logic pulse_rpt_q;

    wire acc = i_psel && i_penable;
    wire wr_ctrl = acc && i_pwrite && (i_paddr == ADDR_CTRL);
    wire wr_cmd = acc && i_pwrite && (i_paddr == ADDR_CMD);
    wire clr_cmd = wr_cmd && i_pwdata[0];
    wire mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STAT) || (i_paddr == ADDR_CMD);
    wire [31:0] ctrl_word = {11'h000, warn_pin_en_q, retry_sel_q, stall_filt_q,
        hold_cyc_q, stall_sel_q, pulse_sel_q};
    wire [31:0] stat_word = {22'h000000, ~o_fault_pin_n, o_bridge_override, sd_flag_q,
        warn_flag_q, ot_flag_q, stall_flag_q, pulse_flag_q, gate_err_q, ctl_err_q, 1'b0};

    assign o_pready = 1'b1;
    assign o_pslverr = acc && !mapped;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pulse_sel_q <= `MDFP_PULSE_SEL_RST;
            stall_sel_q <= `MDFP_STALL_SEL_RST;
            hold_cyc_q <= 4'h0;
            stall_filt_q <= 4'h0;
            retry_sel_q <= 4'h0;
            warn_pin_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            {warn_pin_en_q, retry_sel_q, stall_filt_q, hold_cyc_q, stall_sel_q,
                pulse_sel_q} <= i_pwdata[20:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= (i_paddr == ADDR_CTRL) ? ctrl_word :
                (i_paddr == ADDR_STAT) ? stat_word : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Buck overcurrent deglitch
    // ------------------------------------------------------------
    localparam int OCP_CYC = `MDFP_OCP_DEG_CYC;
    logic [9:0] ocp_cnt_q;
    wire ocp_done = (ocp_cnt_q == 10'(OCP_CYC));
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ocp_cnt_q <= 10'h000;
            o_buck_reset_req <= 1'b0;
        end else begin
            if (!flags.buck_oc) begin
                ocp_cnt_q <= 10'h000;
            end else if (!ocp_done) begin
                ocp_cnt_q <= ocp_cnt_q + 10'h001;
            end
            o_buck_reset_req <= flags.buck_oc && ocp_done;
        end
    end

    // ------------------------------------------------------------
    // Pulse current limit
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PL_IDLE, PL_NEXT, PL_THR, PL_HOLD} mdfp_pl_state_t;
    mdfp_pl_state_t pl_q;
    logic [4:0] hold_left_q;
    wire pulse_over = i_closed_loop ? flags.pulse_over_cl : flags.pulse_over_ol;
    wire pl_active_mode = !pulse_sel_q[3] && (pulse_sel_q[2:1] != 2'b11);
    wire pl_event = pulse_over && pl_active_mode && (pl_q == PL_IDLE);
    wire pl_report = !pulse_sel_q[0];
    wire pl_only = (pulse_sel_q == `MDFP_PL_REPORT);
    wire pl_leave = ((pl_q == PL_NEXT) && flags.pwm_start) || ((pl_q == PL_THR) && !pulse_over) ||
        ((pl_q == PL_HOLD) && flags.pwm_start && (hold_left_q == 5'h01));

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pl_q <= PL_IDLE;
            hold_left_q <= 5'h00;
            pulse_rpt_q <= 1'b0;
        end else begin
            unique case (pl_q)
                PL_IDLE: begin
                    if (pl_event && !pl_only) begin
                        pulse_rpt_q <= pl_report;
                        hold_left_q <= {1'b0, hold_cyc_q} + 5'h01;
                        if (pulse_sel_q[2:1] == 2'b00) begin
                            pl_q <= PL_NEXT;
                        end else if (pulse_sel_q[2:1] == 2'b01) begin
                            pl_q <= PL_THR;
                        end else begin
                            pl_q <= PL_HOLD;
                        end
                    end
                end
                PL_NEXT: begin
                    if (flags.pwm_start) begin
                        pl_q <= PL_IDLE;
                    end
                end
                PL_THR: begin
                    if (!pulse_over) begin
                        pl_q <= PL_IDLE;
                    end
                end
                PL_HOLD: begin
                    if (flags.pwm_start) begin
                        if (hold_left_q == 5'h01) begin
                            pl_q <= PL_IDLE;
                        end
                        hold_left_q <= hold_left_q - 5'h01;
                    end
                end
            endcase
            if (pl_leave) begin
                pulse_rpt_q <= 1'b0;
            end
        end
    end


    wire pl_recirc = (pl_q != PL_IDLE);

    // ------------------------------------------------------------
    // Stall current limit
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_LATCH, ST_RETRY} mdfp_st_state_t;
    mdfp_st_state_t st_q;
    logic [11:0] filt_cnt_q;
    logic [3:0] filt_units_q;
    logic [31:0] retry_cnt_q;
    wire st_ignored = stall_sel_q[`MDFP_ST_MODE_HI] && stall_sel_q[0];
    wire st_report = (stall_sel_q == `MDFP_ST_REPORT);
    wire filt_step = (filt_cnt_q == 12'(`MDFP_STALL_STEP_CYC - 1));
    wire st_event = flags.stall_over && (filt_units_q >= stall_filt_q) && filt_step;
    wire [31:0] retry_len = 32'(RETRY_STEP_CYC) * ({28'h0000000, retry_sel_q} + 32'h1);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            filt_cnt_q <= 12'h000;
            filt_units_q <= 4'h0;
        end else if (!flags.stall_over) begin
            filt_cnt_q <= 12'h000;
            filt_units_q <= 4'h0;
        end else if (filt_step) begin
            filt_cnt_q <= 12'h000;
            if (filt_units_q != 4'hF) begin
                filt_units_q <= filt_units_q + 4'h1;
            end
        end else begin
            filt_cnt_q <= filt_cnt_q + 12'h001;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ST_IDLE;
            retry_cnt_q <= 32'h00000000;
            o_bridge_state <= MDFP_BR_OFF;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (st_event && !st_ignored && !stall_sel_q[`MDFP_ST_MODE_HI]) begin
                        o_bridge_state <= mdfp_bridge_t'(stall_sel_q[1:0]);
                        retry_cnt_q <= 32'h00000000;
                        st_q <= stall_sel_q[`MDFP_ST_MODE_LO] ? ST_RETRY : ST_LATCH;
                    end else if (pl_recirc) begin
                        o_bridge_state <= MDFP_BR_RECIRC;
                    end
                end
                ST_LATCH: begin
                    if (clr_cmd && !flags.stall_over) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_RETRY: begin
                    if (retry_cnt_q >= retry_len - 32'h1) begin
                        st_q <= ST_IDLE;
                    end
                    retry_cnt_q <= retry_cnt_q + 32'h1;
                end
            endcase
        end
    end

    wire st_retry_done = (st_q == ST_RETRY) && (retry_cnt_q >= retry_len - 32'h1);

    // ------------------------------------------------------------
    // Thermal
    // ------------------------------------------------------------
    logic sd_active_q;
    logic warn_pin_q;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sd_active_q <= 1'b0;
            warn_pin_q <= 1'b0;
        end else begin
            if (flags.temp_sd) begin
                sd_active_q <= 1'b1;
            end else if (!flags.temp_sd_hys) begin
                sd_active_q <= 1'b0;
            end
            if (flags.temp_warn && warn_pin_en_q) begin
                warn_pin_q <= 1'b1;
            end else if (!flags.temp_warn_hys || !warn_pin_en_q) begin
                warn_pin_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags; a new event wins over a clear in the same cycle
    // ------------------------------------------------------------
    wire pl_only_evt = pulse_over && pl_only && (pl_q == PL_IDLE);
    wire st_rpt_evt = st_event && st_report;
    wire st_act_evt = st_event && !st_ignored && !stall_sel_q[`MDFP_ST_MODE_HI];
    wire clr_ok_pulse = clr_cmd && !pulse_over;
    wire clr_ok_stall = clr_cmd && !flags.stall_over;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctl_err_q <= 1'b0;
            gate_err_q <= 1'b0;
            pulse_flag_q <= 1'b0;
            stall_flag_q <= 1'b0;
            ot_flag_q <= 1'b0;
            warn_flag_q <= 1'b0;
            sd_flag_q <= 1'b0;
        end else begin
            if ((pl_event && !pl_only) || pl_only_evt) begin
                pulse_flag_q <= 1'b1;
            end else if (pl_leave || (!pl_recirc && clr_ok_pulse)) begin
                pulse_flag_q <= 1'b0;
            end
            if (st_act_evt || st_rpt_evt) begin
                stall_flag_q <= 1'b1;
            end else if (st_retry_done || ((st_q != ST_RETRY) && clr_ok_stall)) begin
                stall_flag_q <= 1'b0;
            end
            if ((pl_event && !pl_only && pl_report) || pl_only_evt || st_act_evt ||
                st_rpt_evt) begin
                ctl_err_q <= 1'b1;
            end else if (st_retry_done || (pl_leave && pulse_rpt_q) ||
                (clr_ok_pulse && clr_ok_stall && (st_q != ST_RETRY) && !pl_recirc)) begin
                ctl_err_q <= 1'b0;
            end
            if (flags.temp_warn || flags.temp_sd) begin
                ot_flag_q <= 1'b1;
            end else if (clr_cmd) begin
                ot_flag_q <= 1'b0;
            end
            if (flags.temp_warn) begin
                warn_flag_q <= 1'b1;
            end else if (clr_cmd) begin
                warn_flag_q <= 1'b0;
            end
            if (flags.temp_sd) begin
                sd_flag_q <= 1'b1;
                gate_err_q <= 1'b1;
            end else if (clr_cmd && !sd_active_q) begin
                sd_flag_q <= 1'b0;
                gate_err_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs: stall bridge state has priority over pulse limit; shutdown only sets override, pin and pump
    // ------------------------------------------------------------
    wire st_hold = (st_q != ST_IDLE);
    wire pin_low = sd_active_q || st_hold || warn_pin_q || (pl_recirc && pulse_rpt_q);
    assign o_fault_pin_n = !pin_low;
    assign o_bridge_override = sd_active_q || st_hold || pl_recirc;
    assign o_charge_pump_en = !sd_active_q;
endmodule

// ===== tb/mdfp_fault_chk.sv
// Port-level checker for the fault response block.
// Assumes a bind onto the top; CTRL shadowed from writes.
`timescale 1ns/1ns
module mdfp_fault_chk
    import mdfp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_buck_oc_raw,
    input wire logic i_pulse_over_cl_raw,
    input wire logic i_pulse_over_ol_raw,
    input wire logic i_stall_over_raw,
    input wire logic i_temp_sd_raw,
    input wire logic i_temp_sd_hys_raw,
    input wire logic i_pwm_start_raw,
    input wire logic i_closed_loop,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_fault_pin_n,
    input wire logic o_bridge_override,
    input wire mdfp_bridge_t o_bridge_state,
    input wire logic o_charge_pump_en,
    input wire logic o_buck_reset_req
);
    logic [20:0] ctrl_q;
    logic [8:0] oc_cnt_q;
    logic [8:0] st_cnt_q;
    wire ctrl_wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr == 12'h000;
    wire st_quiet = i_stall_over_raw && !i_temp_sd_raw && !i_temp_sd_hys_raw;
    // Saturating, so a long fault never wraps into a low window
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= 21'h0;
            oc_cnt_q <= 9'h0;
            st_cnt_q <= 9'h0;
        end else begin
            ctrl_q <= ctrl_wr ? i_pwdata[20:0] : ctrl_q;
            oc_cnt_q <= !i_buck_oc_raw ? 9'h0 : oc_cnt_q + 9'(oc_cnt_q != 9'h1FF);
            st_cnt_q <= !st_quiet ? 9'h0 : st_cnt_q + 9'(st_cnt_q != 9'h1FF);
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    a_sd_cuts_pump: assert property (
        i_temp_sd_raw [*4] |-> !o_charge_pump_en && !o_fault_pin_n)
        else $error("pump or pin wrong in shutdown");
    a_sd_pump_back: assert property (
        (!i_temp_sd_raw && !i_temp_sd_hys_raw) [*5] |-> o_charge_pump_en)
        else $error("pump not back after shutdown");
    a_buck_early_off: assert property (
        oc_cnt_q inside {[10:200]} |-> !o_buck_reset_req)
        else $error("early buck reset");
    a_buck_req_on: assert property (oc_cnt_q == 9'd256 |-> o_buck_reset_req)
        else $error("buck reset missing");
    a_cbc_thr_pin: assert property (
        (ctrl_q[3:0] == 4'h2 && i_closed_loop && i_pulse_over_cl_raw) [*6] |-> !o_fault_pin_n)
        else $error("pin high in threshold mode");
    a_cbc_hold_pin: assert property (
        (ctrl_q[3:0] == 4'h4 && !i_closed_loop && i_pulse_over_ol_raw && !i_pwm_start_raw) [*6]
        |-> !o_fault_pin_n)
        else $error("pin high in hold mode");
    a_stall_bridge: assert property (
        st_cnt_q == 9'd300 && ctrl_q[7:6] == 2'b00 && ctrl_q[3:0] == 4'h7 && ctrl_q[15:12] == 4'h0
        |-> o_bridge_override && !o_fault_pin_n && o_bridge_state == mdfp_bridge_t'(ctrl_q[5:4]))
        else $error("stall bridge wrong");
    a_stall_report: assert property (st_cnt_q == 9'd300 && ctrl_q[7:0] == 8'h87
        |-> !o_bridge_override)
        else $error("report stall drove bridge");
    a_bad_addr: assert property (
        i_psel && i_penable && i_paddr > 12'h008 |-> o_pslverr && o_pready)
        else $error("unmapped access accepted");
endmodule

// ===== tb/mdfp_ctl_model.sv
// Controller model: APB master that reads status and clears faults.
// Assumes a slave on the same clock.
`timescale 1ns/1ns
module mdfp_ctl_model (
    input wire logic i_clk,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr,
    output logic o_psel = 1'b0,
    output logic o_penable = 1'b0,
    output logic o_pwrite = 1'b0,
    output logic [11:0] o_paddr = 12'h000,
    output logic [31:0] o_pwdata = 32'h0
);
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= wd;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Released write data inverts so stale data never looks valid
        o_pwdata <= ~wd;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        xfer(1'b1, a, wd, d, e);
    endtask
    task automatic clr;
        wr(12'h008, 32'h1);
    endtask
endmodule

// ===== tb/test_motor_drive_fault_protection.sv
// Bench: APB sequences with expected status.
// Assumes design, checker and controller model compiled first.
`timescale 1ns/1ns
module test_motor_drive_fault_protection;
    import mdfp_pkg::*;
    localparam int RETRY_CYC = 40;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic oc = 0, pcl = 0, pol = 0, st = 0, tw = 0, twh = 0, thermal_shutdown_flag = 0, tsdh = 0, pwm = 0, cl = 1;
    logic psel, pen, pwr, prdy, perr, pin_n, ovr, pump, breq;
    logic [11:0] padr;
    logic [31:0] pwd, prd;
    mdfp_bridge_t bst;
    int fail_count = 0;
    int check_count = 0;
    logic [3:0] rcode [4] = '{4'h6, 4'h7, 4'h8, 4'hF};
    always #2 clk = ~clk;
    mdfp_top #(.RETRY_STEP_CYC(RETRY_CYC)) dut (.i_core_clk(clk), .i_nrst(nrst),
        .i_buck_oc_raw(oc), .i_pulse_over_cl_raw(pcl), .i_pulse_over_ol_raw(pol),
        .i_stall_over_raw(st), .i_temp_warn_raw(tw), .i_temp_warn_hys_raw(twh),
        .i_temp_sd_raw(thermal_shutdown_flag), .i_temp_sd_hys_raw(tsdh), .i_pwm_start_raw(pwm), .i_closed_loop(cl),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .o_fault_pin_n(pin_n),
        .o_bridge_override(ovr), .o_bridge_state(bst), .o_charge_pump_en(pump),
        .o_buck_reset_req(breq));
    mdfp_ctl_model ctl (.i_clk(clk), .i_prdata(prd), .i_pready(prdy), .i_pslverr(perr),
        .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(padr), .o_pwdata(pwd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stat(input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        ctl.xfer(1'b0, 12'h004, 32'h0, d, e);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pwm_tick;
        @(posedge clk) pwm <= 1'b1;
        @(posedge clk) pwm <= 1'b0;
        cyc(4);
    endtask
    task automatic results;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #40000;
        fail_count++;
        results();
    end
    initial begin
        logic [31:0] d;
        logic e;
        cyc(4);
        nrst <= 1'b1;
        stat(32'h0);
        ctl.xfer(1'b0, 12'h00C, 32'h0, d, e);
        chk({d[30:0], e}, 32'h1);
        #1 chk({28'h0, pin_n, pump, ovr, breq}, 32'hC);
        for (int c = 0; c < 4; c++) begin
            ctl.wr(12'h000, {28'h0, 4'(c)});
            @(posedge clk) pcl <= 1'b1;
            cyc(4);
            if (c >= 2) pwm_tick();
            stat(c[0] ? 32'h108 : 32'h30A);
            @(posedge clk) pcl <= 1'b0;
            if (c < 2) pwm_tick(); else cyc(6);
            stat(32'h0);
        end
        for (int c = 4; c < 6; c++) begin
            ctl.wr(12'h000, {20'h0, 4'h1, 4'h0, 4'(c)});
            @(posedge clk) begin cl <= 1'b0; pcl <= 1'b1; end
            cyc(4);
            stat(32'h0);
            @(posedge clk) begin pcl <= 1'b0; pol <= 1'b1; end
            cyc(6);
            @(posedge clk) pol <= 1'b0;
            pwm_tick();
            stat(c == 4 ? 32'h30A : 32'h108);
            pwm_tick();
            stat(32'h0);
        end
        cl <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ctl.wr(12'h000, {28'h0, rcode[i]});
            @(posedge clk) pcl <= 1'b1;
            cyc(4);
            stat(i == 0 ? 32'h00A : 32'h0);
            @(posedge clk) pcl <= 1'b0;
            cyc(4);
            stat(i == 0 ? 32'h00A : 32'h0);
            ctl.clr();
            stat(32'h0);
        end
        for (int b = 0; b < 4; b++) begin
            ctl.wr(12'h000, {24'h0, 4'(b), 4'h7});
            @(posedge clk) st <= 1'b1;
            cyc(240);
            stat(32'h0);
            cyc(60);
            stat(32'h312);
            #1 chk({30'h0, bst}, 32'(b));
            @(posedge clk) st <= 1'b0;
            cyc(6);
            stat(32'h312);
            ctl.clr();
            stat(32'h0);
        end
        ctl.wr(12'h000, 32'h57);
        @(posedge clk) st <= 1'b1;
        for (int n = 0; n < 400 && pin_n !== 1'b0; n++) @(posedge clk);
        @(posedge clk) st <= 1'b0;
        stat(32'h312);
        cyc(RETRY_CYC + 10);
        stat(32'h0);
        for (int i = 0; i < 2; i++) begin
            ctl.wr(12'h000, {24'h0, 4'(8 + i), 4'h7});
            @(posedge clk) st <= 1'b1;
            cyc(300);
            @(posedge clk) st <= 1'b0;
            cyc(4);
            stat(i == 0 ? 32'h012 : 32'h0);
            ctl.clr();
            stat(32'h0);
        end
        @(posedge clk) begin tw <= 1'b1; twh <= 1'b1; end
        cyc(4);
        stat(32'h060);
        ctl.wr(12'h000, 32'h0010_0097);
        stat(32'h260);
        ctl.clr();
        stat(32'h260);
        @(posedge clk) tw <= 1'b0;
        cyc(4);
        stat(32'h260);
        @(posedge clk) twh <= 1'b0;
        cyc(4);
        stat(32'h060);
        ctl.clr();
        stat(32'h0);
        @(posedge clk) begin thermal_shutdown_flag <= 1'b1; tsdh <= 1'b1; end
        cyc(4);
        stat(32'h3A4);
        #1 chk({31'h0, pump}, 32'h0);
        @(posedge clk) thermal_shutdown_flag <= 1'b0;
        cyc(4);
        stat(32'h3A4);
        @(posedge clk) tsdh <= 1'b0;
        cyc(4);
        stat(32'h0A4);
        ctl.clr();
        stat(32'h0);
        @(posedge clk) oc <= 1'b1;
        cyc(240);
        #1 chk({31'h0, breq}, 32'h0);
        cyc(20);
        #1 chk({31'h0, breq}, 32'h1);
        @(posedge clk) oc <= 1'b0;
        cyc(6);
        #1 chk({31'h0, breq}, 32'h0);
        results();
    end
endmodule
bind mdfp_top mdfp_fault_chk u_chk (.*);
